/* dcmmp_params.svh */
// Purpose: constants for the dc motor motion profiler
// Assumes: 40 MHz clock
// Notes:   times in their own unit, cycle counts derived
`ifndef DCMMP_PARAMS_SVH
`define DCMMP_PARAMS_SVH
`define DCMMP_CLK_HZ          40000000
`define DCMMP_PULSES_PER_REV  2
`define DCMMP_STORE_DELAY_S   5
`define DCMMP_STORE_CYCLES    (`DCMMP_STORE_DELAY_S * `DCMMP_CLK_HZ)
`define DCMMP_RAMP_TICK_US    1000
`define DCMMP_RAMP_TICK_CYC   ((`DCMMP_RAMP_TICK_US * (`DCMMP_CLK_HZ / 1000000)))
`define DCMMP_MEAS_WIN_MS     100
`define DCMMP_MEAS_WIN_CYC    (`DCMMP_MEAS_WIN_MS * (`DCMMP_CLK_HZ / 1000))
`define DCMMP_LOW_SPEED_PCT   10
`define DCMMP_POS_TOL         3
`endif

/* dcmmp_pkg.sv */
// Purpose: types for the dc motor motion profiler
// Assumes: nothing
// Notes:   one-hot run states
package dcmmp_pkg;
  typedef enum logic [3:0]
  {
    DCMMP_IDLE  = 4'h1,
    DCMMP_RUN   = 4'h2,
    DCMMP_HALT  = 4'h4,
    DCMMP_SAVE  = 4'h8
  } dcmmp_state_t;

  typedef struct packed
  {
    logic        start;
    logic        forward_rotation;
    logic        power_down;
  } dcmmp_cmd_t;

  typedef struct packed
  {
    logic        valid;
    logic [31:0] position;
  } dcmmp_nv_t;
endpackage : dcmmp_pkg

/* dcmmp_profiler.sv */
// Purpose: speed ramps, limit deceleration, pid+ff drive and position keeping
// Assumes: hall pulses and commands already synchronous to clk_in
// Notes:   pwm stage and nv memory are outside; drive_out is a signed duty
`include "dcmmp_params.svh"
module dcmmp_profiler #(
  parameter int          SPD_W        = 16,
  parameter int          POS_W        = 32,
  parameter logic [15:0] MAX_SPEED    = 16'h39D0,
  parameter int          STORE_CYCLES = `DCMMP_STORE_CYCLES,
  parameter int          MEAS_CYCLES  = `DCMMP_MEAS_WIN_CYC
) (
  input  wire logic                     clk_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     enable_in,
  input  wire dcmmp_pkg::dcmmp_cmd_t    cmd_in,
  input  wire logic                     hall_pulse_in,
  input  wire logic [SPD_W-1:0]         speed_cmd_in,
  input  wire logic [15:0]              ramp_ms_in,
  input  wire logic [POS_W-1:0]         forward_limit_in,
  input  wire logic [POS_W-1:0]         reverse_limit_in,
  input  wire logic [POS_W-1:0]         decel_dist_in,
  input  wire logic [SPD_W-1:0]         zone_min_speed_in,
  input  wire logic [7:0]               kp_in,
  input  wire logic [7:0]               ki_in,
  input  wire logic [7:0]               kd_in,
  input  wire logic [7:0]               kff_in,
  input  wire dcmmp_pkg::dcmmp_nv_t     nv_load_in,
  input  wire logic                     nv_done_in,
  output logic signed [SPD_W:0]         drive_out,
  output logic [SPD_W-1:0]              speed_out,
  output logic signed [POS_W-1:0]       position_out,
  output logic                          moving_out,
  output logic                          nv_write_out,
  output logic [POS_W-1:0]              nv_data_out,
  output logic                          stored_out
);
  localparam logic [SPD_W-1:0] LOW_SPEED =
    SPD_W'((32'(MAX_SPEED) * `DCMMP_LOW_SPEED_PCT) / 100);

  dcmmp_pkg::dcmmp_state_t state_q;
  logic              [SPD_W-1:0] ramp_q;
  logic              [SPD_W-1:0] target_d;
  logic                          dir_q;
  logic                          hall_q;
  logic              [31:0]      win_q;
  logic              [SPD_W-1:0] cnt_q;
  logic              [31:0]      tick_q;
  logic              [31:0]      idle_q;
  logic signed       [POS_W-1:0] last_saved_q;
  logic signed       [31:0]      integ_q;
  logic signed       [31:0]      err_prev_q;
  logic                          restored_q;

  wire hall_edge = hall_pulse_in & ~hall_q;
  wire run_req   = cmd_in.start & ~cmd_in.power_down;
  // reversal drops the target to zero; dir_q waits until the shaft stands
  wire reversing = (state_q == dcmmp_pkg::DCMMP_RUN) && (cmd_in.forward_rotation != dir_q);
  // outside RUN the setpoint is zero at once, so stop needs no ramp
  wire [SPD_W-1:0] set_speed = (state_q == dcmmp_pkg::DCMMP_RUN) ? ramp_q : '0;

  function automatic logic [POS_W-1:0] dist_to(input logic [POS_W-1:0] a,
                                                input logic [POS_W-1:0] b);
    dist_to = (a > b) ? a - b : '0;
  endfunction : dist_to

  function automatic logic [SPD_W-1:0] max_spd(input logic [SPD_W-1:0] a,
                                               input logic [SPD_W-1:0] b);
    max_spd = (a > b) ? a : b;
  endfunction : max_spd

  // remaining travel toward the active limit
  logic [POS_W-1:0] room;
  always_comb
  begin
    if (dir_q)
      room = dist_to(forward_limit_in, position_out);
    else
      room = dist_to(position_out, reverse_limit_in);
  end

  // decel distance grows with speed, capped by the programmed maximum
  logic [POS_W-1:0] dyn_dist;
  always_comb
  begin
    dyn_dist = POS_W'((64'(decel_dist_in) * speed_out) / MAX_SPEED);
    if (dyn_dist > decel_dist_in)
      dyn_dist = decel_dist_in;
  end

  always_comb
  begin
    if (state_q != dcmmp_pkg::DCMMP_RUN)
      target_d = '0;
    else if (room == '0)
      target_d = '0;
    else if (reversing)
      target_d = '0;
    else if (room <= dyn_dist)
      target_d = max_spd(zone_min_speed_in, LOW_SPEED);
    else
      target_d = speed_cmd_in;
  end

  // speed and position from hall edges
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      hall_q       <= 1'b0;
      win_q        <= '0;
      cnt_q        <= '0;
      speed_out    <= '0;
      position_out <= '0;
      restored_q   <= 1'b0;
    end
    else if (enable_in)
    begin
      hall_q <= hall_pulse_in;
      if (!restored_q && nv_load_in.valid)
      begin
        position_out <= nv_load_in.position;
        restored_q   <= 1'b1;
      end
      else if (hall_edge)
        position_out <= dir_q ? position_out + 1'b1 : position_out - 1'b1;
      if (win_q == 32'(MEAS_CYCLES - 1))
      begin
        win_q     <= '0;
        speed_out <= SPD_W'(32'(cnt_q) * 600 / (`DCMMP_PULSES_PER_REV * `DCMMP_MEAS_WIN_MS));
        cnt_q     <= SPD_W'(hall_edge);
      end
      else
      begin
        win_q <= win_q + 1'b1;
        if (hall_edge)
          cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ramp generator; step per tick scaled so a full ramp spans ramp_ms_in
  logic [SPD_W-1:0] step;
  always_comb
  begin
    step = (ramp_ms_in == 16'h0000) ? MAX_SPEED : SPD_W'(MAX_SPEED / ramp_ms_in);
    if (step == '0)
      step = SPD_W'(1);
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      ramp_q <= '0;
      tick_q <= '0;
    end
    else if (enable_in)
    begin
      if (state_q != dcmmp_pkg::DCMMP_RUN)
        ramp_q <= '0;
      else if (target_d <= LOW_SPEED && ramp_q <= LOW_SPEED)
        ramp_q <= target_d;
      else if (tick_q == 32'(`DCMMP_RAMP_TICK_CYC - 1))
      begin
        // lower speeds finish sooner since the step is fixed against max speed
        if (ramp_q < target_d)
          ramp_q <= (target_d - ramp_q < step) ? target_d : ramp_q + step;
        else if (ramp_q > target_d)
          ramp_q <= (ramp_q - target_d < step) ? target_d : ramp_q - step;
      end
      tick_q <= (tick_q == 32'(`DCMMP_RAMP_TICK_CYC - 1)) ? '0 : tick_q + 1'b1;
    end
  end

  // run state and direction handling
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= dcmmp_pkg::DCMMP_IDLE;
      dir_q   <= 1'b1;
    end
    else if (enable_in)
    begin
      case (state_q)
        dcmmp_pkg::DCMMP_IDLE:
        begin
          // late pulses of a coasting shaft must still count the old way
          if (speed_out == '0)
            dir_q <= cmd_in.forward_rotation;
          if (cmd_in.power_down)
            state_q <= dcmmp_pkg::DCMMP_SAVE;
          else if (run_req && restored_q)
            state_q <= dcmmp_pkg::DCMMP_RUN;
        end
        dcmmp_pkg::DCMMP_RUN:
        begin
          // reversal: ramp falls from present speed to zero, then climbs again
          if (cmd_in.forward_rotation != dir_q && ramp_q == '0 && speed_out == '0)
            dir_q <= cmd_in.forward_rotation;
          if (cmd_in.power_down)
            state_q <= dcmmp_pkg::DCMMP_SAVE;
          else if (!cmd_in.start)
            state_q <= dcmmp_pkg::DCMMP_IDLE;
        end
        dcmmp_pkg::DCMMP_SAVE:
          if (nv_done_in)
            state_q <= dcmmp_pkg::DCMMP_HALT;
        dcmmp_pkg::DCMMP_HALT:
          if (!cmd_in.power_down)
            state_q <= dcmmp_pkg::DCMMP_IDLE;
        default:
          state_q <= dcmmp_pkg::DCMMP_IDLE;
      endcase
    end
  end

  // pid on speed plus feedforward; position held by the limit-zone target
  logic signed [31:0] err;
  logic signed [31:0] u;
  always_comb
  begin
    err = $signed({16'h0000, set_speed}) - $signed({16'h0000, speed_out});
    u   = ($signed(32'(kff_in)) * $signed(32'(set_speed))) / 32'sd16
        + ($signed(32'(kp_in)) * err) / 32'sd16
        + integ_q / 32'sd256
        + ($signed(32'(kd_in)) * (err - err_prev_q)) / 32'sd16;
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      integ_q    <= '0;
      err_prev_q <= '0;
      drive_out  <= '0;
      moving_out <= 1'b0;
    end
    else if (enable_in)
    begin
      moving_out <= (set_speed != '0);
      if (set_speed == '0)
      begin
        // integral cleared while the setpoint is zero to avoid windup overshoot at the limits
        integ_q    <= '0;
        err_prev_q <= '0;
        drive_out  <= '0;
      end
      else if (tick_q == '0)
      begin
        err_prev_q <= err;
        integ_q    <= integ_q + $signed(32'(ki_in)) * err;
        if (u < 0)
          drive_out <= '0;
        else if (u > 32'(MAX_SPEED))
          drive_out <= dir_q ? (SPD_W+1)'(MAX_SPEED) : -(SPD_W+1)'(MAX_SPEED);
        else
          drive_out <= dir_q ? (SPD_W+1)'(u) : -(SPD_W+1)'(u);
      end
    end
  end

  // position storage after stop delay or at power-down
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      idle_q       <= '0;
      last_saved_q <= '0;
      nv_write_out <= 1'b0;
      nv_data_out  <= '0;
      stored_out   <= 1'b0;
    end
    else if (enable_in)
    begin
      nv_write_out <= 1'b0;
      if (!restored_q && nv_load_in.valid)
        last_saved_q <= nv_load_in.position;
      if (state_q == dcmmp_pkg::DCMMP_SAVE && !nv_write_out && !stored_out
          && speed_out == '0)
      begin
        nv_write_out <= 1'b1;
        nv_data_out  <= position_out;
        last_saved_q <= position_out;
        stored_out   <= 1'b1;
      end
      else if (state_q == dcmmp_pkg::DCMMP_IDLE)
      begin
        stored_out <= 1'b0;
        if (idle_q == 32'(STORE_CYCLES - 1))
        begin
          idle_q <= idle_q + 1'b1;
          if (position_out != last_saved_q)
          begin
            nv_write_out <= 1'b1;
            nv_data_out  <= position_out;
            last_saved_q <= position_out;
          end
        end
        else if (idle_q < 32'(STORE_CYCLES))
          idle_q <= idle_q + 1'b1;
      end
      else
        idle_q <= '0;
    end
  end
endmodule : dcmmp_profiler

/* dcmmp_profiler_asserts.sv */
// Purpose: port checks for dcmmp_profiler
// Assumes: one clock, sync active-low reset
// Notes:   idle time before a store is counted here in enabled cycles
module dcmmp_profiler_asserts #(
  parameter int SPD_W        = 16,
  parameter int POS_W        = 32,
  parameter int STORE_CYCLES = 100
) (
  input wire logic                    clk_in,
  input wire logic                    reset_n_in,
  input wire logic                    enable_in,
  input wire dcmmp_pkg::dcmmp_cmd_t   cmd_in,
  input wire dcmmp_pkg::dcmmp_nv_t    nv_load_in,
  input wire logic signed [SPD_W:0]   drive_out,
  input wire logic                    moving_out,
  input wire logic                    nv_write_out,
  input wire logic                    stored_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic        restored_q;
  logic        pd_q;
  int unsigned idle_q;
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in) restored_q <= 1'b0;
    else if (nv_load_in.valid) restored_q <= 1'b1;
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in) pd_q <= 1'b0;
    else if (cmd_in.power_down) pd_q <= 1'b1;
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in || moving_out) idle_q <= 0;
    else if (enable_in) idle_q <= idle_q + 1;
  end
  sequence stop_seen;
    moving_out && enable_in && !cmd_in.start && !cmd_in.power_down;
  endsequence
  sequence halted;
    drive_out == '0 && !moving_out;
  endsequence
  halt_on_stop_a : assert property (stop_seen |-> ##[1:2] halted)
    else $error("drive still on after stop");
  still_when_idle_a : assert property ((!moving_out && !pd_q) [*2] |-> drive_out == '0)
    else $error("drive while stopped");
  no_run_unrestored_a : assert property (!restored_q |-> !moving_out)
    else $error("run before position restore");
  run_needs_start_a : assert property ($rose(moving_out) |-> $past(cmd_in.start))
    else $error("run without start");
  write_one_cycle_a : assert property (nv_write_out |=> !nv_write_out)
    else $error("store pulse too long");
  write_after_delay_a : assert property (nv_write_out && !pd_q |-> idle_q >= STORE_CYCLES - 2)
    else $error("store before stop delay");
  write_when_still_a : assert property (nv_write_out |-> halted)
    else $error("store while turning");
  pd_refuse_start_a : assert property (cmd_in.power_down && !moving_out |=> !moving_out)
    else $error("start taken during power down");
  stored_still_a : assert property (stored_out |-> drive_out == '0 && pd_q)
    else $error("stored flag without power down");
endmodule : dcmmp_profiler_asserts

bind dcmmp_profiler dcmmp_profiler_asserts #(
  .SPD_W(SPD_W), .POS_W(POS_W), .STORE_CYCLES(STORE_CYCLES)
) chk_i (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .enable_in(enable_in), .cmd_in(cmd_in),
  .nv_load_in(nv_load_in), .drive_out(drive_out), .moving_out(moving_out),
  .nv_write_out(nv_write_out), .stored_out(stored_out)
);

/* dcmmp_motor_model.sv */
// Purpose: dc motor with hall sensor for the profiler bench
// Assumes: pulse rate follows drive magnitude, no inertia
// Notes:   hall level holds while the shaft stands
module dcmmp_motor_model #(
  parameter int SPD_W = 16,
  parameter int STEP  = 2000
) (
  input  wire logic                  clk_in,
  input  wire logic signed [SPD_W:0] drive_in,
  output logic                       hall_out,
  output logic                       fwd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int acc_q = 0;
  initial hall_out = 1'b0;
  initial fwd_out = 1'b1;
  always @(posedge clk_in)
  begin
    acc_q <= acc_q + ((drive_in < 0) ? -drive_in : drive_in);
    // the shaft keeps its last sense of turning while it coasts out
    if (drive_in != 0)
      fwd_out <= (drive_in > 0);
    if (acc_q >= STEP)
    begin
      acc_q <= 0;
      hall_out <= !hall_out;
    end
  end
endmodule : dcmmp_motor_model

/* dcmmp_profiler_tb.sv */
// Purpose: self-checking bench for dcmmp_profiler
// Assumes: shortened store delay and speed window
// Notes:   ramp ticks stay at 1 ms, so the first run lasts about 42000 cycles, the low-speed second run about 37000
module dcmmp_profiler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STORE = 100;
  logic                  clk_in = 1'b0;
  logic                  reset_n_in = 1'b0;
  logic                  hall, hall_d, nv_done = 1'b0;
  logic                  moving, wr, stored;
  dcmmp_pkg::dcmmp_cmd_t cmd = 3'h2;
  dcmmp_pkg::dcmmp_nv_t  load = '0;
  logic signed [16:0]    drive;
  logic [15:0]           speed, spd = 16'h0BB8;
  logic [7:0]            g = 8'h10;
  logic                  enable = 1'b1;
  logic [15:0]           ramp_ms = 16'h0002;
  logic                  shaft_fwd;
  logic signed [31:0]    pos, mark, pos_exp = '0;
  logic [31:0]           nv_data;
  int                    mismatches = 0;
  int                    check_count = 0;
  int                    writes = 0;
  initial forever #12.5 clk_in = ~clk_in;
  dcmmp_profiler #(.STORE_CYCLES(STORE), .MEAS_CYCLES(1000)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .enable_in(enable), .cmd_in(cmd),
    .hall_pulse_in(hall), .speed_cmd_in(spd), .ramp_ms_in(ramp_ms),
    .forward_limit_in({16'h0001, spd}), .reverse_limit_in(32'h0), .decel_dist_in(32'h40),
    .zone_min_speed_in(16'h05C8), .kp_in(g), .ki_in(g >> 3), .kd_in(g >> 4), .kff_in(g),
    .nv_load_in(load), .nv_done_in(nv_done), .drive_out(drive), .speed_out(speed),
    .position_out(pos), .moving_out(moving), .nv_write_out(wr), .nv_data_out(nv_data),
    .stored_out(stored));
  dcmmp_motor_model #(.SPD_W(16)) motor (.clk_in(clk_in), .drive_in(drive), .hall_out(hall),
    .fwd_out(shaft_fwd));
  always @(posedge clk_in)
  begin
    hall_d <= hall;
    if (load.valid) pos_exp <= load.position;
    else if (hall && !hall_d) pos_exp <= shaft_fwd ? pos_exp + 1 : pos_exp - 1;
    if (wr === 1'b1) writes <= writes + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : cyc
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic wait_wr(input int n);
    for (int i = 0; i < n && wr !== 1'b1; i++) @(negedge clk_in);
    if (wr !== 1'b1)
    begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_wr
  // above the low speed the ramp steps only on the 1 ms tick, so motion may start that late
  task automatic wait_move(input int n);
    for (int i = 0; i < n && moving !== 1'b1; i++) @(negedge clk_in);
  endtask : wait_move
  initial
  begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in) cmd.start <= 1'b1;
    cyc(20);
    chk(32'(moving), 32'h0);
    @(posedge clk_in) load <= {1'b1, 32'h0000_1000};
    @(posedge clk_in) load.valid <= 1'b0;
    cyc(3);
    chk(pos, 32'h0000_1000);
    chk(32'(moving), 32'h0);
    wait_move(41000);
    chk(32'(moving), 32'h1);
    cyc(2000);
    chk(32'(pos > 32'sh1000), 32'h1);
    chk(32'(drive[16]), 32'h0);
    @(posedge clk_in) cmd.start <= 1'b0;
    cyc(2);
    chk(32'(drive), 32'h0);
    cyc(20);
    chk(pos, pos_exp);
    @(posedge clk_in) cmd.forward_rotation <= 1'b0;
    cyc(20);
    chk(32'(drive), 32'h0);
    wait_wr(STORE + 50);
    chk(nv_data, pos_exp);
    cyc(2500);
    chk(32'(writes), 32'h1);
    mark = pos_exp;
    @(posedge clk_in) cmd.start <= 1'b1;
    enable <= 1'b0;
    spd <= 16'h05C8;
    g <= 8'h20;
    cyc(5);
    chk(32'(moving), 32'h0);
    @(posedge clk_in) enable <= 1'b1;
    cyc(3);
    chk(32'(moving), 32'h1);
    cyc(37000);
    chk(32'(pos < mark), 32'h1);
    chk(32'(drive[16]), 32'h1);
    @(posedge clk_in) cmd.forward_rotation <= 1'b1;
    cyc(2);
    chk(32'(drive), 32'h0);
    chk(32'(moving), 32'h0);
    @(posedge clk_in) cmd.forward_rotation <= 1'b0;
    cyc(3);
    chk(32'(moving), 32'h1);
    @(posedge clk_in) cmd.power_down <= 1'b1;
    wait_wr(4000);
    chk(nv_data, pos_exp);
    chk(32'(drive), 32'h0);
    @(posedge clk_in) nv_done <= 1'b1;
    @(posedge clk_in) nv_done <= 1'b0;
    cyc(3);
    chk(32'(stored), 32'h1);
    give_verdict();
  end
endmodule : dcmmp_profiler_tb
